// ### hdl/fis_sequencer.sv
// Furnace ignition sequencer: phases, trials, lockout, retry, LED, limits.
// Assumes all inputs synchronous to i_clk; temperature is an 8-bit value in F.
//
// The implementer's own choices: the address map and the strobed register port.

`timescale 1ns/10ps

module fis_sequencer #(
   parameter fis_pkg::fis_time_type P_PREPURGE = fis_pkg::fis_time_type'(fis_pkg::PREPURGE_CYC),
   parameter fis_pkg::fis_time_type P_TRIAL = fis_pkg::fis_time_type'(fis_pkg::TRIAL_CYC),
   parameter fis_pkg::fis_time_type P_PROVE = fis_pkg::fis_time_type'(fis_pkg::PROVE_CYC),
   parameter fis_pkg::fis_time_type P_POSTPURGE =
      fis_pkg::fis_time_type'(fis_pkg::POSTPURGE_CYC),
   parameter fis_pkg::fis_time_type P_RETRY = fis_pkg::fis_time_type'(fis_pkg::RETRY_CYC),
   parameter fis_pkg::fis_time_type P_SPARK = fis_pkg::fis_time_type'(fis_pkg::SPARK_CYC),
   parameter fis_pkg::fis_time_type P_LOCK_ON = fis_pkg::fis_time_type'(fis_pkg::LOCK_ON_CYC),
   parameter fis_pkg::fis_time_type P_LOCK_OFF =
      fis_pkg::fis_time_type'(fis_pkg::LOCK_OFF_CYC),
   parameter fis_pkg::fis_time_type P_FLICKER =
      fis_pkg::fis_time_type'(fis_pkg::WEAK_FLICKER_CYC)
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_demand,
   input wire logic i_flame,
   input wire logic i_flame_weak,
   input wire logic i_fault,
   input wire logic [7:0] i_temp,
   input wire logic i_blower_relay_contact,
   input wire logic i_modulation_limit_open,
   output fis_pkg::fis_out_type o_act
);
   import fis_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // True on the last cycle of an interval of len cycles
   function automatic logic timer_done(input fis_time_type cnt, input fis_time_type len);
      timer_done = (cnt >= len - fis_time_type'(1));
   endfunction

   fis_ctrl_type ctrl;
   fis_state_type state;
   fis_state_type next_state;
   fis_led_mode_type led_mode;
   fis_time_type phase_cnt;
   fis_time_type retry_cnt;
   fis_time_type spark_cnt;
   fis_time_type led_cnt;
   fis_time_type led_len;
   logic [2:0] trials;
   logic dem_prev;
   logic ext_break;
   logic dem;
   logic limit_latched;
   logic limit_auto_open;
   logic limit_open;
   logic aux_fan;
   logic fail_trial;
   logic relight;
   logic retry_fire;
   logic sleep_var;
   logic late_spark;
   logic spark_on;
   logic led_lit;
   logic limit_reset_wr;

   assign sleep_var = (ctrl.variant == VAR_SLEEP);
   assign late_spark = (ctrl.variant == VAR_LATER) || (ctrl.variant == VAR_FLASH);
   // One-cycle break keeps the thermostat path honest without a second timer
   assign dem = i_demand && !ext_break;
   assign limit_reset_wr = i_wr && (i_addr == ADDR_LIMIT_RESET) && i_wdata[0];

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl <= fis_ctrl_type'(CTRL_RESET);
      end else if (i_ce && i_wr && (i_addr == ADDR_CTRL)) begin
         ctrl <= fis_ctrl_type'(i_wdata[CTRL_W-1:0]);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0;
      end else if (i_ce) begin
         o_rdata <= 32'h0;
         if (i_rd) begin
            unique case (i_addr)
               ADDR_CTRL: o_rdata[CTRL_W-1:0] <= ctrl;
               ADDR_STATUS: begin
                  o_rdata[ST_STATE_LSB +: 4] <= state;
                  o_rdata[ST_TRIALS_LSB +: 3] <= trials;
                  o_rdata[ST_LIMIT_BIT] <= limit_open;
                  o_rdata[ST_AUX_BIT] <= aux_fan;
                  o_rdata[ST_LED_BIT] <= o_act.led;
                  o_rdata[ST_GAS_BIT] <= o_act.gas_valve;
               end
               default: o_rdata <= 32'h0;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Blower compartment limits
   // ------------------------------------------------------------
   // Manual limit: trip wins over a reset written in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         limit_latched <= 1'b0;
      end else if (i_ce) begin
         if (!ctrl.auto_limit && (i_temp >= HOUSING_TRIP_F)) begin
            limit_latched <= 1'b1;
         end else if (limit_reset_wr || ctrl.auto_limit) begin
            limit_latched <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         limit_auto_open <= 1'b0;
      end else if (i_ce) begin
         if (!ctrl.auto_limit) begin
            limit_auto_open <= 1'b0;
         end else if (i_temp >= AUTO_OPEN_F) begin
            limit_auto_open <= 1'b1;
         end else if (i_temp <= AUTO_CLOSE_F) begin
            limit_auto_open <= 1'b0;
         end
      end
   end

   assign limit_open = limit_latched || limit_auto_open;
   assign aux_fan = (i_temp >= AUX_FAN_F);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   assign fail_trial = dem && !i_flame &&
      (((state == S_IGNITE) && timer_done(phase_cnt, P_TRIAL)) || (state == S_PROVE));
   assign retry_fire = timer_done(retry_cnt, P_RETRY);
   // A rising demand in lockout implies it was removed first
   assign relight = (state == S_LOCKOUT) &&
      ((dem && !dem_prev) || (retry_fire && !sleep_var));

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: begin
            if (dem) begin
               next_state = S_PREPURGE;
            end
         end
         S_PREPURGE: begin
            if (!dem) begin
               next_state = S_IDLE;
            end else if (timer_done(phase_cnt, P_PREPURGE)) begin
               next_state = S_IGNITE;
            end
         end
         S_IGNITE: begin
            if (!dem) begin
               next_state = S_POSTPURGE;
            end else if (i_flame) begin
               next_state = S_PROVE;
            end else if (fail_trial) begin
               next_state = (trials + 3'h1 >= MAX_TRIALS) ? S_LOCKOUT : S_PREPURGE;
            end
         end
         S_PROVE: begin
            if (!dem) begin
               next_state = S_POSTPURGE;
            end else if (fail_trial) begin
               next_state = (trials + 3'h1 >= MAX_TRIALS) ? S_LOCKOUT : S_PREPURGE;
            end else if (timer_done(phase_cnt, P_PROVE)) begin
               next_state = S_SENSE;
            end
         end
         S_SENSE: begin
            if (!dem) begin
               next_state = S_POSTPURGE;
            end else if (!i_flame) begin
               next_state = S_PREPURGE;
            end
         end
         S_POSTPURGE: begin
            if (timer_done(phase_cnt, P_POSTPURGE)) begin
               next_state = S_IDLE;
            end
         end
         S_LOCKOUT: begin
            if (relight) begin
               next_state = S_IDLE;
            end
         end
         S_DORMANT: next_state = S_DORMANT;
      endcase
      // Self-test failure shuts every variant down; only reset leaves it
      if (i_fault) begin
         next_state = S_DORMANT;
      end else if (limit_open && (state != S_DORMANT)) begin
         next_state = S_IDLE;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= S_IDLE;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_cnt <= '0;
      end else if (i_ce) begin
         if (next_state != state) begin
            phase_cnt <= '0;
         end else if (phase_cnt != '1) begin
            phase_cnt <= phase_cnt + fis_time_type'(1);
         end
      end
   end

   // Consecutive failures only; a proven flame or a limit trip restarts the count
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         trials <= 3'h0;
      end else if (i_ce) begin
         if (relight || limit_open || (state == S_SENSE)) begin
            trials <= 3'h0;
         end else if (fail_trial && (state != next_state)) begin
            trials <= trials + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dem_prev <= 1'b0;
      end else if (i_ce) begin
         dem_prev <= dem;
      end
   end

   // ------------------------------------------------------------
   // Retry timer: in lockout, or on continuous demand for sleep variant
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         retry_cnt <= '0;
         ext_break <= 1'b0;
      end else if (i_ce) begin
         ext_break <= 1'b0;
         if (sleep_var) begin
            if (!i_demand || ext_break) begin
               retry_cnt <= '0;
            end else if (retry_fire) begin
               retry_cnt <= '0;
               ext_break <= 1'b1;
            end else begin
               retry_cnt <= retry_cnt + fis_time_type'(1);
            end
         end else if ((state != S_LOCKOUT) || retry_fire) begin
            retry_cnt <= '0;
         end else begin
            retry_cnt <= retry_cnt + fis_time_type'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Spark timing for the later variants
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         spark_on <= 1'b0;
         spark_cnt <= '0;
      end else if (i_ce) begin
         if (!late_spark || !(next_state inside {S_IGNITE, S_PROVE, S_SENSE})) begin
            spark_on <= 1'b0;
            spark_cnt <= '0;
         end else if ((next_state == S_IGNITE) && (state != S_IGNITE)) begin
            spark_on <= 1'b1;
            spark_cnt <= '0;
         end else if (spark_on) begin
            if (timer_done(spark_cnt, P_SPARK)) begin
               spark_on <= 1'b0;
            end
            spark_cnt <= spark_cnt + fis_time_type'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Diagnostic LED
   // ------------------------------------------------------------
   always_comb begin
      if (sleep_var) begin
         led_mode = (state inside {S_LOCKOUT, S_POSTPURGE, S_DORMANT}) ?
            LED_LIT : LED_DARK;
      end else if (state == S_DORMANT) begin
         led_mode = LED_DARK;
      end else if (state == S_LOCKOUT) begin
         led_mode = LED_LOCK_FLASH;
      end else if ((ctrl.variant == VAR_FLASH) && (state == S_SENSE) && i_flame_weak) begin
         led_mode = LED_FLICKER;
      end else begin
         led_mode = LED_LIT;
      end
   end

   // Older flashing variants reuse the on time for both halves
   always_comb begin
      if (led_mode == LED_FLICKER) begin
         led_len = P_FLICKER;
      end else if (led_lit) begin
         led_len = P_LOCK_ON;
      end else if (ctrl.variant == VAR_FLASH) begin
         led_len = P_LOCK_OFF;
      end else begin
         led_len = P_LOCK_ON;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         led_lit <= 1'b0;
         led_cnt <= '0;
      end else if (i_ce) begin
         if ((led_mode == LED_DARK) || (led_mode == LED_LIT)) begin
            led_lit <= (led_mode == LED_LIT);
            led_cnt <= '0;
         end else if (timer_done(led_cnt, led_len)) begin
            led_lit <= !led_lit;
            led_cnt <= '0;
         end else begin
            led_cnt <= led_cnt + fis_time_type'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Registered actuator outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_act <= '0;
      end else if (i_ce) begin
         o_act.gas_valve <= (state inside {S_IGNITE, S_PROVE, S_SENSE});
         o_act.spark <= late_spark ? spark_on :
            ((state == S_IGNITE) && !i_flame);
         o_act.purge_blower <=
            (state inside {S_PREPURGE, S_IGNITE, S_PROVE, S_POSTPURGE});
         o_act.indoor_blower_heat <= !ctrl.variable_speed &&
            (i_blower_relay_contact || aux_fan);
         o_act.blower_request <= ctrl.variable_speed &&
            (aux_fan || i_modulation_limit_open);
         o_act.led <= led_lit;
      end
   end

endmodule

// ### hdl/fis_pkg.sv
// Constants, types and register map of the furnace ignition sequencer.
// Assumes a single 100 MHz system clock shared by every user of this package.

package fis_pkg;

   // ------------------------------------------------------------
   // Clock and time base
   // ------------------------------------------------------------
   localparam longint CLK_HZ = 100_000_000;
   localparam int TIME_W = 40;
   typedef logic [TIME_W-1:0] fis_time_type;

   // Times in their own unit, cycles derived from the clock rate
   localparam longint RETRY_TIME_S = 3600;
   localparam longint SPARK_TIME_S = 8;
   localparam longint LOCK_ON_MS = 500;
   localparam longint LOCK_OFF_MS = 2500;
   localparam longint WEAK_FLICKER_MS = 100;
   localparam longint PREPURGE_MS = 30000;
   localparam longint TRIAL_MS = 8000;
   localparam longint PROVE_MS = 1000;
   localparam longint POSTPURGE_MS = 30000;

   localparam longint RETRY_CYC = RETRY_TIME_S * CLK_HZ;
   localparam longint SPARK_CYC = SPARK_TIME_S * CLK_HZ;
   localparam longint LOCK_ON_CYC = (LOCK_ON_MS * CLK_HZ + 999) / 1000;
   localparam longint LOCK_OFF_CYC = (LOCK_OFF_MS * CLK_HZ + 999) / 1000;
   localparam longint WEAK_FLICKER_CYC = (WEAK_FLICKER_MS * CLK_HZ + 999) / 1000;
   localparam longint PREPURGE_CYC = (PREPURGE_MS * CLK_HZ + 999) / 1000;
   localparam longint TRIAL_CYC = (TRIAL_MS * CLK_HZ) / 1000;
   localparam longint PROVE_CYC = (PROVE_MS * CLK_HZ + 999) / 1000;
   localparam longint POSTPURGE_CYC = (POSTPURGE_MS * CLK_HZ + 999) / 1000;

   // ------------------------------------------------------------
   // Trials and temperatures (degrees F)
   // ------------------------------------------------------------
   localparam logic [2:0] MAX_TRIALS = 3'h5;
   localparam logic [7:0] HOUSING_TRIP_F = 8'hA0;
   localparam logic [7:0] AUTO_OPEN_F = 8'h82;
   localparam logic [7:0] AUTO_CLOSE_F = 8'h6E;
   localparam logic [7:0] AUX_FAN_F = 8'h8C;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_LIMIT_RESET = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CTRL_W = 4;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_TRIALS_LSB = 4;
   localparam int ST_LIMIT_BIT = 7;
   localparam int ST_AUX_BIT = 8;
   localparam int ST_LED_BIT = 9;
   localparam int ST_GAS_BIT = 10;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      VAR_SLEEP,
      VAR_EARLY,
      VAR_LATER,
      VAR_FLASH
   } fis_variant_type;

   typedef enum logic [3:0] {
      S_IDLE,
      S_PREPURGE,
      S_IGNITE,
      S_PROVE,
      S_SENSE,
      S_POSTPURGE,
      S_LOCKOUT,
      S_DORMANT
   } fis_state_type;

   typedef enum logic [1:0] {
      LED_DARK,
      LED_LIT,
      LED_LOCK_FLASH,
      LED_FLICKER
   } fis_led_mode_type;

   typedef struct packed {
      logic variable_speed;
      logic auto_limit;
      fis_variant_type variant;
   } fis_ctrl_type;

   typedef struct packed {
      logic gas_valve;
      logic spark;
      logic purge_blower;
      logic indoor_blower_heat;
      logic blower_request;
      logic led;
   } fis_out_type;

endpackage

// ### testbench/fis_seq_props.sv
// Checker of the sequencer outputs against their causes.
// Bound into every fis_sequencer; sees its ports only.
`timescale 1ns/10ps
module fis_seq_props
   import fis_pkg::*;
#(
   parameter fis_pkg::fis_time_type P_TRIAL = 40'h14
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_rd,
   input wire logic i_flame,
   input wire logic i_fault,
   input wire logic [7:0] i_temp,
   input wire logic [31:0] o_rdata,
   input wire fis_pkg::fis_out_type o_act
);
   // ------------------------------------------------------------
   // Helpers and properties
   // ------------------------------------------------------------
   logic seen;
   logic seen_q;
   fis_time_type spk;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_hot; (i_temp >= HOUSING_TRIP_F) [*2]; endsequence
   sequence s_lit; $rose(o_act.gas_valve); endsequence
   // Sticky, since only reset may end dormancy
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         seen <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         seen <= seen | i_fault;
         seen_q <= seen;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         spk <= '0;
      end else begin
         spk <= o_act.spark ? spk + 40'h1 : '0;
      end
   end
   AST_SPARK_GAS: assert property (o_act.spark |-> o_act.gas_valve)
      else $error("spark without gas");
   AST_SPARK_LEN: assert property (spk <= P_TRIAL + 40'h1)
      else $error("spark too long");
   AST_PURGE_FIRST: assert property (s_lit |-> $past(o_act.purge_blower))
      else $error("gas without prepurge");
   AST_FLAME_LOSS: assert property (
      o_act.gas_valve && $fell(i_flame) |-> ##[1:3] !o_act.gas_valve)
      else $error("gas kept after flame loss");
   AST_HOT_TRIP: assert property (s_hot |-> ##[1:2] !o_act.gas_valve)
      else $error("gas on with housing hot");
   AST_AUX_FAN: assert property (
      (i_temp >= AUX_FAN_F) [*3] |-> o_act.indoor_blower_heat || o_act.blower_request)
      else $error("blower not forced");
   AST_FAULT_OFF: assert property (
      seen_q |-> !o_act.gas_valve && !o_act.spark && !o_act.purge_blower)
      else $error("running after fault");
   AST_RD_QUIET: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside slot");
endmodule

bind fis_sequencer fis_seq_props #(.P_TRIAL(P_TRIAL)) u_props (
   .i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd), .i_flame(i_flame), .i_fault(i_fault),
   .i_temp(i_temp), .o_rdata(o_rdata), .o_act(o_act)
);

// ### testbench/fis_furnace_model.sv
// Furnace side: flame starts on spark while gas flows.
// Driven by the sequencer outputs; bench steers lighting.
`timescale 1ns/10ps
module fis_furnace_model
   import fis_pkg::*;
(
   input wire logic i_clk,
   input wire fis_pkg::fis_out_type i_act,
   input wire logic i_lights,
   output logic o_flame
);
   // ------------------------------------------------------------
   // Flame
   // ------------------------------------------------------------
   // Dies with the gas; a dark burner never lights
   always_ff @(posedge i_clk) begin
      o_flame <= i_act.gas_valve && i_lights && (o_flame || i_act.spark);
   end
endmodule

// ### testbench/fis_sequencer_bench.sv
// Self-checking bench of the ignition sequencer with a furnace model.
// Phase counts shrunk by parameters; expectations use those values.
`timescale 1ns/10ps
module fis_sequencer_bench;
   import fis_pkg::*;
   typedef struct {logic [31:0] m; logic [31:0] e;} fis_note_type;
   // ------------------------------------------------------------
   // Bench
   // ------------------------------------------------------------
   localparam fis_time_type T_ON = 40'h5;
   localparam fis_time_type T_OFF = 40'hF;
   localparam fis_time_type T_FLK = 40'h3;
   localparam fis_time_type T_PHASE = 40'h14;
   localparam fis_time_type T_PRV = 40'h5;
   localparam fis_time_type T_RTY = 40'hC8;
   localparam fis_time_type T_SPK = 40'hA;
   logic i_clk, i_rst, i_wr, i_rd, i_demand, i_weak, i_fault, i_relay, i_mod;
   logic lights, flame, rd_pend, ce;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [7:0] temp;
   fis_out_type act;
   fis_note_type notes[$];
   int errors, n_tests, n;

   fis_sequencer #(
      .P_PREPURGE(T_PHASE), .P_TRIAL(T_PHASE), .P_PROVE(T_PRV), .P_POSTPURGE(T_PHASE),
      .P_RETRY(T_RTY), .P_SPARK(T_SPK), .P_LOCK_ON(T_ON), .P_LOCK_OFF(T_OFF),
      .P_FLICKER(T_FLK)
   ) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_demand(i_demand), .i_flame(flame),
      .i_flame_weak(i_weak), .i_fault(i_fault), .i_temp(temp),
      .i_blower_relay_contact(i_relay), .i_modulation_limit_open(i_mod), .o_act(act)
   );
   fis_furnace_model furnace (.i_clk(i_clk), .i_act(act), .i_lights(lights), .o_flame(flame));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      notes.push_back('{m, e});
      addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic st(input logic [3:0] s, input logic g, input logic l);
      rd(ADDR_STATUS, 32'h60F, {21'h0, g, l, 5'h0, s});
   endtask

   task automatic lim(input logic [7:0] t, input logic [31:0] e);
      temp <= t;
      cyc(3);
      rd(ADDR_STATUS, 32'h80, e);
   endtask

   task automatic look(input int b, input logic v);
      @(negedge i_clk);
      check("act", act[b], v);
      @(posedge i_clk);
   endtask

   // Bounded wait for one output bit
   task automatic wb(input int b, input logic v);
      int k = 0;
      do begin
         @(negedge i_clk);
         k++;
      end while (act[b] !== v && k < 900);
      check("wait", act[b], v);
      @(posedge i_clk);
   endtask

   // Length of the next lamp run; leaves at the negedge that ends it
   task automatic span(input logic v, output int len);
      int k = 0;
      while (act.led !== v && k < 999) begin
         @(negedge i_clk);
         k++;
      end
      len = 0;
      while (act.led === v && len < 999) begin
         len++;
         @(negedge i_clk);
      end
   endtask

   task automatic lockout;
      repeat (5) begin
         wb(5, 1'b1);
         wb(5, 1'b0);
      end
      cyc(2);
   endtask

   // Read results land one cycle after the strobe
   always @(posedge i_clk) rd_pend <= i_rd;
   always @(negedge i_clk) begin
      if (rd_pend === 1'b1) begin
         check("rdata", rdata & notes[0].m, notes[0].e);
         void'(notes.pop_front());
      end
   end

   // Whole run is near 1200 cycles; ten thousand is ample
   initial begin
      #100000;
      errors++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      i_rst = 1'b1;
      ce = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      i_demand = 1'b0;
      i_weak = 1'b0;
      i_fault = 1'b0;
      i_relay = 1'b0;
      i_mod = 1'b0;
      temp = 8'h46;
      lights = 1'b1;
      errors = 0;
      n_tests = 0;
      void'($urandom(32'h6FB4));
      cyc(20);
      i_rst <= 1'b0;
      @(posedge i_clk);
      wr(ADDR_CTRL, 32'h2);
      i_demand <= 1'b1;
      wb(5, 1'b1);
      cyc(4);
      look(4, 1'b1);
      wb(3, 1'b0);
      st(4'h4, 1'b1, 1'b1);
      lights <= 1'b0;
      wb(5, 1'b0);
      rd(ADDR_STATUS, 32'h7F, 32'h1);
      wr(ADDR_CTRL, 32'h1);
      lights <= 1'b1;
      wb(5, 1'b1);
      cyc(4);
      look(4, 1'b0);
      wb(3, 1'b0);
      i_demand <= 1'b0;
      cyc(3);
      st(4'h5, 1'b0, 1'b1);
      cyc(25);
      st(4'h0, 1'b0, 1'b1);
      $display("test cycle done");
      wr(ADDR_CTRL, 32'h3);
      lights <= 1'b0;
      i_demand <= 1'b1;
      lockout();
      rd(ADDR_STATUS, 32'h40F, 32'h6);
      @(negedge i_clk);
      span(1'b0, n);
      span(1'b1, n);
      check("lock on", n, T_ON[31:0]);
      span(1'b0, n);
      check("lock off", n, T_OFF[31:0]);
      @(posedge i_clk);
      i_demand <= 1'b0;
      cyc(3);
      rd(ADDR_STATUS, 32'hF, 32'h6);
      i_demand <= 1'b1;
      cyc(3);
      rd(ADDR_STATUS, 32'h7F, 32'h1);
      wr(ADDR_CTRL, 32'h1);
      lockout();
      @(negedge i_clk);
      span(1'b0, n);
      span(1'b1, n);
      check("lock on 1", n, T_ON[31:0]);
      span(1'b0, n);
      check("lock off 1", n, T_ON[31:0]);
      @(posedge i_clk);
      cyc(150);
      rd(ADDR_STATUS, 32'hF, 32'h6);
      cyc(35);
      rd(ADDR_STATUS, 32'hF, 32'h1);
      $display("test lockout done");
      lights <= 1'b1;
      i_demand <= 1'b0;
      cyc(25);
      wr(ADDR_CTRL, 32'h0);
      i_demand <= 1'b1;
      cyc(100);
      st(4'h4, 1'b1, 1'b0);
      cyc(104);
      st(4'h5, 1'b0, 1'b1);
      wr(ADDR_CTRL, 32'h3);
      i_weak <= 1'b1;
      wb(5, 1'b1);
      wb(3, 1'b0);
      @(negedge i_clk);
      span(1'b0, n);
      span(1'b1, n);
      check("flick on", n, T_FLK[31:0]);
      span(1'b0, n);
      check("flick off", n, T_FLK[31:0]);
      @(posedge i_clk);
      i_weak <= 1'b0;
      $display("test lamp done");
      lim(HOUSING_TRIP_F, 32'h80);
      lim(8'($urandom_range(159, 0)), 32'h80);
      wr(ADDR_LIMIT_RESET, 32'h1);
      rd(ADDR_STATUS, 32'h80, 32'h0);
      temp <= AUX_FAN_F;
      cyc(3);
      look(2, 1'b1);
      temp <= 8'($urandom_range(139, 0));
      i_relay <= 1'b1;
      cyc(3);
      look(2, 1'b1);
      i_relay <= 1'b0;
      cyc(3);
      look(2, 1'b0);
      wr(ADDR_CTRL, 32'hF);
      i_mod <= 1'b1;
      cyc(3);
      look(1, 1'b1);
      i_mod <= 1'b0;
      cyc(3);
      look(1, 1'b0);
      lim(AUTO_OPEN_F, 32'h80);
      lim(8'h78, 32'h80);
      lim(AUTO_CLOSE_F, 32'h0);
      $display("test limits done");
      rd(ADDR_CTRL, 32'hFFFFFFFF, 32'hF);
      rd(4'hC, 32'hFFFFFFFF, 32'h0);
      rd(ADDR_LIMIT_RESET, 32'hFFFFFFFF, 32'h0);
      wr(ADDR_CTRL, 32'h3);
      i_fault <= 1'b1;
      cyc(2);
      i_fault <= 1'b0;
      i_demand <= 1'b0;
      cyc(3);
      i_demand <= 1'b1;
      cyc(3);
      st(4'h7, 1'b0, 1'b0);
      i_demand <= 1'b0;
      i_rst <= 1'b1;
      cyc(2);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(ADDR_STATUS, 32'h7F, 32'h0);
      rd(ADDR_CTRL, 32'hF, 32'h0);
      $display("test fault done");
      // Enable low must hold the sequencer in idle despite demand
      ce <= 1'b0;
      i_demand <= 1'b1;
      cyc(30);
      ce <= 1'b1;
      rd(ADDR_STATUS, 32'hF, 32'h0);
      cyc(3);
      rd(ADDR_STATUS, 32'hF, 32'h1);
      $display("test freeze done");
      close_out();
   end
endmodule
